// >>> index_arith_unit_32.sv
// index arithmetic unit: order buffer, one-hot function decode, adder, logic unit, handshakes
`timescale 1ns/100ps

module index_arith_unit_32 (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic highway_input_strobe,
   input wire index_arith_pkg::order_in_t order_in,
   input wire logic transfer_complete_in,
   input wire logic overflow_mask_bit,
   output logic ready_for_order_pulse,
   output logic buffer_empty_flag,
   output logic unit_inactive_flag,
   output index_arith_pkg::store_out_t store_out,
   output logic [index_arith_pkg::WORD_W-1:0] modifier_data_out,
   output logic modifier_ready_pulse,
   output index_arith_pkg::test_out_t test_out,
   output logic overflow_fault_out
);
   import index_arith_pkg::*;

   typedef enum logic [1:0] {ST_IDLE, ST_EXEC, ST_STORE_WAIT, ST_MOD} exec_state_t;

   typedef struct packed {
      logic strobe_s1;
      logic strobe_s2;
      logic strobe_s3;
      logic tc_s1;
      logic tc_s2;
      logic mask_s1;
      logic mask_s2;
      order_in_t pin_s1;
      order_in_t pin_s2;
      logic buf_full;
      logic [HW_W-1:0] operand_input_buffer;
      logic [3:0] function_input_buffer;
      logic [3:0] function_input_buffer_copy;
      logic [3:0] intreg_select_buffer;
      logic buf_route;
      logic buf_mod;
      logic buf_iro;
      exec_state_t st;
      logic [HW_W-1:0] operand_reg_copy;
      logic [WORD_W:0] second_operand_reg;
      logic [WORD_W:0] second_operand_slave_reg;
      logic [15:0] onehot_function_flops;
      logic [3:0] intreg_sel;
      logic ex_route;
      logic ex_mod;
      logic ex_iro;
      logic [WORD_W-1:0] adder_out_reg;
      logic [WORD_W-1:0] logic_out_reg;
      logic [WORD_W-1:0] accumulator_reg;
      logic [HW_W-1:0] intreg0;
      logic [HW_W-1:0] intreg1;
      logic [WORD_W-1:0] overflow_condition_field;
      logic [3:0] empty_cnt;
      logic [3:0] mod_cnt;
      logic rdy;
      logic bempty;
      logic binact;
      store_out_t so;
      logic [WORD_W-1:0] mod_data;
      logic mod_pulse;
      test_out_t tst;
      logic fault;
   } state_t;

   state_t s_q;
   state_t s_d;

   // highway lanes carry bits 0-15 and 32-63; 16-31 are always zero
   function automatic logic [HW_W-1:0] unpack_lanes(input logic [LANE_W-1:0] l);
      unpack_lanes = {l[LANE_W-1:16], 16'h0000, l[15:0]};
   endfunction

   function automatic logic [LANE_W-1:0] pack_lanes(input logic [HW_W-1:0] w);
      pack_lanes = {w[HW_W-1:HI_HALF_LSB], w[15:0]};
   endfunction

   function automatic logic sel_one(input logic [3:0] code);
      sel_one = code[0];
   endfunction

   logic [WORD_W-1:0] op_b;
   logic [WORD_W:0] sum;
   logic ovf;
   logic fn_is_store;

   always_comb begin
      s_d = s_q;
      // highway bits 32-63 (upper verilog half) are the least significant word
      op_b = s_q.operand_reg_copy[HW_W-1:HI_HALF_LSB];
      sum = '0;
      ovf = 1'b0;
      fn_is_store = s_q.onehot_function_flops[FN_STORE];
      s_d.rdy = 1'b0;
      s_d.tst.test_result_strobe = 1'b0;
      // pins pass two flops before use
      s_d.strobe_s1 = highway_input_strobe;
      s_d.strobe_s2 = s_q.strobe_s1;
      s_d.strobe_s3 = s_q.strobe_s2;
      s_d.tc_s1 = transfer_complete_in;
      s_d.tc_s2 = s_q.tc_s1;
      s_d.mask_s1 = overflow_mask_bit;
      s_d.mask_s2 = s_q.mask_s1;
      s_d.pin_s1 = order_in;
      s_d.pin_s2 = s_q.pin_s1;

      // capture on rising edge of the synchronised strobe
      if (s_q.strobe_s2 && !s_q.strobe_s3 && !s_q.buf_full) begin
         s_d.buf_full = 1'b1;
         s_d.operand_input_buffer = unpack_lanes(s_q.pin_s2.data);
         s_d.function_input_buffer = s_q.pin_s2.function_code_bits;
         s_d.function_input_buffer_copy = s_q.pin_s2.function_code_bits;
         s_d.intreg_select_buffer = s_q.pin_s2.intreg_select_bits;
         s_d.buf_route = s_q.pin_s2.route_select_bit;
         s_d.buf_mod = s_q.pin_s2.modifier_request_bit;
         s_d.buf_iro = s_q.pin_s2.intreg_order_flag;
         s_d.bempty = 1'b0;
         s_d.binact = 1'b0;
         s_d.empty_cnt = '0;
      end else if (!s_q.buf_full && !s_q.bempty) begin
         // no order arrived soon enough after ready
         if (s_q.empty_cnt >= 4'(EMPTY_WAIT_CYC - 1))
            s_d.bempty = 1'b1;
         else
            s_d.empty_cnt = s_q.empty_cnt + 4'h1;
      end

      unique case (s_q.st)
         ST_IDLE: begin
            if (s_q.buf_full) begin
               // transfer buffer into operand registers and decode function
               s_d.buf_full = 1'b0;
               s_d.operand_reg_copy = s_q.operand_input_buffer;
               s_d.second_operand_reg = {1'b0, s_q.operand_input_buffer[HW_W-1:HI_HALF_LSB]};
               s_d.onehot_function_flops = 16'h0001 << s_q.function_input_buffer;
               s_d.intreg_sel = s_q.intreg_select_buffer;
               s_d.ex_route = s_q.buf_route;
               s_d.ex_mod = s_q.buf_mod;
               s_d.ex_iro = s_q.buf_iro;
               s_d.rdy = 1'b1;
               s_d.empty_cnt = '0;
               s_d.st = ST_EXEC;
            end else if (!s_q.bempty || !s_q.binact) begin
               // a capture in this cycle must not be masked by the lagging copy
               s_d.binact = s_q.bempty && s_d.bempty;
            end
         end
         ST_EXEC: begin
            s_d.second_operand_slave_reg = s_q.second_operand_reg;
            s_d.st = s_q.ex_mod ? ST_MOD : ST_IDLE;
            if (s_q.ex_iro) begin
               if (fn_is_store) begin
                  // internal register write: only the 48 lane bits significant, bits 16-31 always zero
                  if (sel_one(s_q.intreg_sel))
                     s_d.intreg1 = s_q.operand_reg_copy;
                  else
                     s_d.intreg0 = s_q.operand_reg_copy;
               end else begin
                  s_d.so.data = pack_lanes(sel_one(s_q.intreg_sel) ? s_q.intreg1 : s_q.intreg0);
                  s_d.so.store_data_present = 1'b1;
                  s_d.so.route_echo_out = s_q.ex_route;
                  s_d.overflow_condition_field[OVF_BIT] = 1'b0;
                  s_d.st = ST_STORE_WAIT;
               end
            end else begin
               unique case (1'b1)
                  s_q.onehot_function_flops[FN_LOAD],
                  s_q.onehot_function_flops[FN_STACK_LOAD]: begin
                     sum = {1'b0, op_b};
                     s_d.adder_out_reg = sum[WORD_W-1:0];
                     s_d.accumulator_reg = sum[WORD_W-1:0];
                  end
                  s_q.onehot_function_flops[FN_LOAD_DEC],
                  s_q.onehot_function_flops[FN_ADD],
                  s_q.onehot_function_flops[FN_SUB],
                  s_q.onehot_function_flops[FN_RSUB],
                  s_q.onehot_function_flops[FN_COMP],
                  s_q.onehot_function_flops[FN_COMP_INC],
                  s_q.onehot_function_flops[FN_MUL]: begin
                     // multiply is reduced to add here; iterative loop not modelled
                     logic [WORD_W-1:0] a;
                     logic [WORD_W-1:0] b;
                     logic cin;
                     a = s_q.accumulator_reg;
                     b = op_b;
                     cin = 1'b0;
                     if (s_q.onehot_function_flops[FN_LOAD_DEC]) begin
                        a = op_b;
                        b = '1;
                     end else if (s_q.onehot_function_flops[FN_SUB] ||
                                  s_q.onehot_function_flops[FN_COMP] ||
                                  s_q.onehot_function_flops[FN_COMP_INC]) begin
                        b = ~op_b;
                        cin = 1'b1;
                     end else if (s_q.onehot_function_flops[FN_RSUB]) begin
                        a = ~s_q.accumulator_reg;
                        cin = 1'b1;
                     end
                     sum = {1'b0, a} + {1'b0, b} + {32'h0, cin};
                     ovf = (a[WORD_W-1] == b[WORD_W-1]) && (sum[WORD_W-1] != a[WORD_W-1]);
                     s_d.adder_out_reg = sum[WORD_W-1:0];
                     if (s_q.onehot_function_flops[FN_COMP] ||
                         s_q.onehot_function_flops[FN_COMP_INC]) begin
                        // sign corrected on overflow before testing
                        s_d.tst.test_result_lines = {sum[WORD_W-1] ^ ovf,
                                                     sum[WORD_W-1:0] != '0, ovf};
                        s_d.tst.test_result_strobe = 1'b1;
                        if (s_q.onehot_function_flops[FN_COMP_INC])
                           s_d.accumulator_reg = s_q.accumulator_reg + 32'h1;
                     end else begin
                        s_d.accumulator_reg = sum[WORD_W-1:0];
                     end
                     if (ovf)
                        s_d.overflow_condition_field[OVF_BIT] = 1'b1;
                  end
                  s_q.onehot_function_flops[FN_AND],
                  s_q.onehot_function_flops[FN_OR],
                  s_q.onehot_function_flops[FN_XOR]: begin
                     logic [WORD_W-1:0] lr;
                     lr = s_q.accumulator_reg ^ op_b;
                     if (s_q.onehot_function_flops[FN_AND])
                        lr = s_q.accumulator_reg & op_b;
                     else if (s_q.onehot_function_flops[FN_OR])
                        lr = s_q.accumulator_reg | op_b;
                     s_d.logic_out_reg = lr;
                     s_d.accumulator_reg = lr;
                  end
                  s_q.onehot_function_flops[FN_SHIFT]: begin
                     // single-pass shift from second_operand_reg, not the slave copy; count low 5 bits, bit 31 sign
                     logic [4:0] cnt;
                     cnt = s_q.second_operand_reg[4:0];
                     if (s_q.second_operand_reg[WORD_W-1])
                        s_d.accumulator_reg = WORD_W'($signed(op_b) >>> (~cnt + 5'h1));
                     else
                        s_d.accumulator_reg = op_b << cnt;
                  end
                  s_q.onehot_function_flops[FN_STORE]: begin
                     s_d.so.data = pack_lanes({s_q.accumulator_reg, 32'h0});
                     s_d.so.store_data_present = 1'b1;
                     s_d.so.route_echo_out = s_q.ex_route;
                     s_d.st = ST_STORE_WAIT;
                  end
                  default: begin
                     // divide and reverse divide: accepted, no effect
                     s_d.accumulator_reg = s_q.accumulator_reg;
                  end
               endcase
            end
         end
         ST_STORE_WAIT: begin
            if (s_q.tc_s2) begin
               s_d.so.store_data_present = 1'b0;
               s_d.so.route_echo_out = 1'b0;
               s_d.st = s_q.ex_mod ? ST_MOD : ST_IDLE;
            end
         end
         ST_MOD: begin
            if (!s_q.mod_pulse) begin
               s_d.mod_data = s_q.accumulator_reg;
               s_d.mod_pulse = 1'b1;
               s_d.mod_cnt = 4'(MOD_PULSE_CYC - 1);
            end else if (s_q.mod_cnt == 4'h0) begin
               s_d.mod_pulse = 1'b0;
               s_d.st = ST_IDLE;
            end else begin
               s_d.mod_cnt = s_q.mod_cnt - 4'h1;
            end
         end
      endcase
      s_d.fault = s_d.overflow_condition_field[OVF_BIT] && !s_q.mask_s2;
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         s_q <= '0;
         s_q.bempty <= 1'b1;
         s_q.binact <= 1'b1;
         s_q.st <= ST_IDLE;
      end else begin
         s_q <= s_d;
      end
   end

   assign ready_for_order_pulse = s_q.rdy;
   assign buffer_empty_flag = s_q.bempty;
   assign unit_inactive_flag = s_q.binact;
   assign store_out = s_q.so;
   assign modifier_data_out = s_q.mod_data;
   assign modifier_ready_pulse = s_q.mod_pulse;
   assign test_out = s_q.tst;
   assign overflow_fault_out = s_q.fault;
endmodule // index_arith_unit_32

// >>> index_arith_pkg.sv
// package: constants, function codes and carrier structs for the index arithmetic unit
package index_arith_pkg;
   localparam int unsigned SYS_CLK_MHZ = 20;
   localparam int unsigned EMPTY_WAIT_NS = 25;
   localparam int unsigned EMPTY_WAIT_CYC_RAW = (EMPTY_WAIT_NS * SYS_CLK_MHZ + 999) / 1000;
   localparam int unsigned EMPTY_WAIT_CYC = (EMPTY_WAIT_CYC_RAW < 1) ? 1 : EMPTY_WAIT_CYC_RAW;
   localparam int unsigned MOD_PULSE_NS = 20;
   localparam int unsigned MOD_PULSE_CYC_RAW = (MOD_PULSE_NS * SYS_CLK_MHZ) / 1000;
   localparam int unsigned MOD_PULSE_CYC = (MOD_PULSE_CYC_RAW < 1) ? 1 : MOD_PULSE_CYC_RAW;
   localparam int unsigned WORD_W = 32;
   localparam int unsigned HW_W = 64;
   localparam int unsigned LANE_W = 48;
   localparam int unsigned LO_HALF_LSB = 0;
   localparam int unsigned HI_HALF_LSB = 32;
   localparam int unsigned OVF_BIT = 0;
   localparam int unsigned MASK_BIT = 4;
   localparam logic [3:0] FN_LOAD = 4'h0;
   localparam logic [3:0] FN_LOAD_DEC = 4'h1;
   localparam logic [3:0] FN_STACK_LOAD = 4'h2;
   localparam logic [3:0] FN_STORE = 4'h3;
   localparam logic [3:0] FN_ADD = 4'h4;
   localparam logic [3:0] FN_SUB = 4'h5;
   localparam logic [3:0] FN_MUL = 4'h6;
   localparam logic [3:0] FN_DIV = 4'h7;
   localparam logic [3:0] FN_XOR = 4'h8;
   localparam logic [3:0] FN_OR = 4'h9;
   localparam logic [3:0] FN_SHIFT = 4'ha;
   localparam logic [3:0] FN_AND = 4'hb;
   localparam logic [3:0] FN_RSUB = 4'hc;
   localparam logic [3:0] FN_COMP = 4'hd;
   localparam logic [3:0] FN_RDIV = 4'he;
   localparam logic [3:0] FN_COMP_INC = 4'hf;

   typedef struct packed {
      logic [LANE_W-1:0] data;
      logic [3:0] function_code_bits;
      logic [3:0] intreg_select_bits;
      logic route_select_bit;
      logic modifier_request_bit;
      logic intreg_order_flag;
   } order_in_t;

   typedef struct packed {
      logic store_data_present;
      logic route_echo_out;
      logic [LANE_W-1:0] data;
   } store_out_t;

   typedef struct packed {
      logic test_result_strobe;
      logic [2:0] test_result_lines;
   } test_out_t;
endpackage

// >>> index_arith_checker.sv
// checker: port-level assertions for the index arithmetic unit
`timescale 1ns/100ps
module index_arith_checker (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic highway_input_strobe,
   input wire index_arith_pkg::order_in_t order_in,
   input wire logic transfer_complete_in,
   input wire logic overflow_mask_bit,
   input wire logic ready_for_order_pulse,
   input wire logic buffer_empty_flag,
   input wire logic unit_inactive_flag,
   input wire index_arith_pkg::store_out_t store_out,
   input wire logic [index_arith_pkg::WORD_W-1:0] modifier_data_out,
   input wire logic modifier_ready_pulse,
   input wire index_arith_pkg::test_out_t test_out,
   input wire logic overflow_fault_out
);
   import index_arith_pkg::*;
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst);
   sequence strobe_taken;
      $rose(highway_input_strobe) ##1 highway_input_strobe;
   endsequence
   sequence ready_then_quiet;
      ready_for_order_pulse ##1 !highway_input_strobe [*5];
   endsequence
   AST_READY_PULSE: assert property (
      $rose(ready_for_order_pulse) |=> !ready_for_order_pulse) else $error("ready too long");
   AST_STROBE_CLEARS: assert property (
      strobe_taken |-> ##[1:3] (!buffer_empty_flag && !unit_inactive_flag))
      else $error("flags not cleared by strobe");
   AST_READY_FOLLOWS: assert property (
      strobe_taken ##0 unit_inactive_flag |-> ##[1:4] ready_for_order_pulse)
      else $error("no ready after order taken");
   AST_EMPTY_AFTER_READY: assert property (
      ready_then_quiet |-> ##[0:2] buffer_empty_flag) else $error("buffer empty missing");
   AST_INACTIVE_EMPTY: assert property (
      unit_inactive_flag |-> buffer_empty_flag) else $error("inactive while buffered");
   AST_STORE_HOLD: assert property (
      store_out.store_data_present && !transfer_complete_in |=>
      store_out.store_data_present && $stable(store_out.data)) else $error("store dropped");
   AST_ROUTE_STABLE: assert property (
      store_out.store_data_present ##1 store_out.store_data_present |->
      $stable(store_out.route_echo_out)) else $error("route echo moved");
   AST_MOD_PULSE: assert property (
      modifier_ready_pulse |=> !modifier_ready_pulse && $stable(modifier_data_out))
      else $error("modifier pulse wrong");
   AST_MASK_FAULT: assert property (
      overflow_mask_bit [*4] |-> !overflow_fault_out) else $error("fault while masked");
   AST_TEST_PULSE: assert property (
      test_out.test_result_strobe |=> !test_out.test_result_strobe) else $error("test strobe");
endmodule // index_arith_checker

bind index_arith_unit_32 index_arith_checker i_index_arith_checker (.sys_clk, .rst,
   .highway_input_strobe, .order_in, .transfer_complete_in, .overflow_mask_bit,
   .ready_for_order_pulse, .buffer_empty_flag, .unit_inactive_flag, .store_out,
   .modifier_data_out, .modifier_ready_pulse, .test_out, .overflow_fault_out);

// >>> highway_partner.sv
// highway partner: order sender, store acknowledger, modifier catcher
`timescale 1ns/100ps
module highway_partner (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic ready_for_order_pulse,
   input wire index_arith_pkg::store_out_t store_out,
   input wire logic [index_arith_pkg::WORD_W-1:0] modifier_data_out,
   input wire logic modifier_ready_pulse,
   input wire logic [3:0] ack_delay,
   output index_arith_pkg::order_in_t order_in,
   output logic highway_input_strobe,
   output logic transfer_complete_in,
   output logic [index_arith_pkg::WORD_W-1:0] modifier_seen
);
   import index_arith_pkg::*;
   logic [3:0] wait_q = 4'h0;
   initial begin
      highway_input_strobe = 1'b0;
      order_in = '0;
      transfer_complete_in = 1'b0;
   end
   // strobe held until ready is sampled; released order lines show inverted junk
   task automatic send_order(input order_in_t o);
      int n;
      n = 0;
      @(posedge sys_clk);
      highway_input_strobe <= 1'b1;
      order_in <= o;
      do begin
         @(posedge sys_clk);
         n++;
      end while (ready_for_order_pulse !== 1'b1 && n < 60);
      highway_input_strobe <= 1'b0;
      order_in <= ~o;
      @(posedge sys_clk);
   endtask
   // ack only after data taken; delay lets the bench play a slow highway
   always @(posedge sys_clk) begin
      if (rst || store_out.store_data_present !== 1'b1) begin
         transfer_complete_in <= 1'b0;
         wait_q <= 4'h0;
      end else if (wait_q >= ack_delay) begin
         transfer_complete_in <= 1'b1;
      end else begin
         wait_q <= wait_q + 4'h1;
      end
      if (modifier_ready_pulse === 1'b1) begin
         modifier_seen <= modifier_data_out;
      end
   end
endmodule // highway_partner

// >>> index_arith_unit_32_tb.sv
// testbench for the index arithmetic unit
`timescale 1ns/100ps
module index_arith_unit_32_tb;
   import index_arith_pkg::*;
   logic sys_clk, rst, highway_input_strobe, transfer_complete_in, overflow_mask_bit;
   logic ready_for_order_pulse, buffer_empty_flag, unit_inactive_flag, modifier_ready_pulse;
   logic overflow_fault_out;
   order_in_t order_in;
   store_out_t store_out;
   test_out_t test_out;
   logic [WORD_W-1:0] modifier_data_out, modifier_seen;
   logic [3:0] ack_delay;
   logic [2:0] tests_seen;
   int mismatches = 0;
   int n_compared = 0;
   int cycles = 0;
   logic [3:0] fns [10] = '{FN_LOAD, FN_ADD, FN_SUB, FN_RSUB, FN_AND, FN_OR, FN_XOR, FN_DIV,
      FN_RDIV, FN_LOAD_DEC};
   logic [31:0] opnd [10] = '{5, 3, 2, 'ha, 'hc, 3, 5, 1, 9, 'h10};
   logic [31:0] expv [10] = '{5, 8, 6, 4, 4, 7, 2, 2, 2, 'hf};
   index_arith_unit_32 i_index_arith_unit_32 (.sys_clk, .rst, .highway_input_strobe, .order_in,
      .transfer_complete_in, .overflow_mask_bit, .ready_for_order_pulse, .buffer_empty_flag,
      .unit_inactive_flag, .store_out, .modifier_data_out, .modifier_ready_pulse, .test_out,
      .overflow_fault_out);
   highway_partner i_highway_partner (.sys_clk, .rst, .ready_for_order_pulse, .store_out,
      .modifier_data_out, .modifier_ready_pulse, .ack_delay, .order_in, .highway_input_strobe,
      .transfer_complete_in, .modifier_seen);
   initial begin
      sys_clk = 1'b0;
      forever #25 sys_clk = ~sys_clk;
   end
   task automatic wrap_up();
      $display("compared %0d mismatches %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   always @(posedge sys_clk) begin
      cycles++;
      if (test_out.test_result_strobe === 1'b1) tests_seen <= test_out.test_result_lines;
      if (cycles == 6000) begin
         mismatches++;
         wrap_up();
      end
   end
   task automatic check(input logic [63:0] seen, input logic [63:0] exp);
      n_compared++;
      if (seen !== exp) begin
         mismatches++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   // low lane junk must be ignored; flags = route, modifier request, internal register order
   function automatic order_in_t mk(logic [3:0] fn, logic [31:0] v, logic [2:0] flags);
      return '{data: {v, 16'hbeef}, function_code_bits: fn, intreg_select_bits: 4'h2,
         route_select_bit: flags[2], modifier_request_bit: flags[1], intreg_order_flag: flags[0]};
   endfunction
   // accumulator read back through the modifier path
   task automatic op(input logic [3:0] fn, input logic [31:0] v, input logic [31:0] exp);
      int n;
      n = 0;
      i_highway_partner.send_order(mk(fn, v, 3'b010));
      while (modifier_ready_pulse !== 1'b1 && n < 20) begin
         @(posedge sys_clk);
         n++;
      end
      @(posedge sys_clk);
      check({32'h0, modifier_seen}, {32'h0, exp});
   endtask
   task automatic compare_case();
      op(FN_LOAD, 32'h5, 32'h5);
      op(FN_COMP, 32'h7, 32'h5);
      check({61'h0, tests_seen}, {61'h0, 3'b110});
      op(FN_COMP_INC, 32'h5, 32'h6);
      check({61'h0, tests_seen}, 64'h0);
   endtask
   task automatic store_case(input logic route, input logic [3:0] dly, input logic [31:0] v);
      int n;
      n = 0;
      ack_delay <= dly;
      op(FN_LOAD, v, v);
      i_highway_partner.send_order(mk(FN_STORE, 32'h0, {route, 2'b00}));
      while (transfer_complete_in !== 1'b1 && n < 40) begin
         @(posedge sys_clk);
         n++;
      end
      check({62'h0, store_out.store_data_present, store_out.route_echo_out}, {62'h1, route});
      check({16'h0, store_out.data}, {16'h0, v, 16'h0});
      repeat (4) @(posedge sys_clk);
      check({63'h0, store_out.store_data_present}, 64'h0);
   endtask
   task automatic fault_case();
      op(FN_LOAD, 32'h7fffffff, 32'h7fffffff);
      op(FN_ADD, 32'h1, 32'h80000000);
      check({63'h0, overflow_fault_out}, 64'h1);
      overflow_mask_bit <= 1'b1;
      repeat (4) @(posedge sys_clk);
      check({63'h0, overflow_fault_out}, 64'h0);
      overflow_mask_bit <= 1'b0;
      repeat (4) @(posedge sys_clk);
      check({63'h0, overflow_fault_out}, 64'h1);
      ack_delay <= 4'h1;
      i_highway_partner.send_order(mk(FN_LOAD, 32'h0, 3'b001));
      repeat (12) @(posedge sys_clk);
      check({63'h0, overflow_fault_out}, 64'h0);
   endtask
   initial begin
      rst = 1'b1;
      overflow_mask_bit = 1'b0;
      ack_delay = 4'h0;
      tests_seen = 3'h0;
      repeat (4) @(posedge sys_clk);
      check({59'h0, buffer_empty_flag, unit_inactive_flag, ready_for_order_pulse,
         store_out.store_data_present, overflow_fault_out}, {59'h0, 5'b11000});
      rst <= 1'b0;
      for (int i = 0; i < 10; i++) op(fns[i], opnd[i], expv[i]);
      compare_case();
      store_case(1'b1, 4'h6, 32'h12345678);
      store_case(1'b0, 4'h0, 32'h8765abcd);
      fault_case();
      repeat (10) @(posedge sys_clk);
      check({62'h0, buffer_empty_flag, unit_inactive_flag}, {62'h0, 2'b11});
      wrap_up();
   end
endmodule // index_arith_unit_32_tb
